// ### logic/dspl_status_pins.sv
// Start-up strap capture and operation-mode status pin drive.
// Assumes all inputs synchronous to clk; the decoder core supplies
// header words, frame strobes and lock/clock-valid levels.
`timescale 1ns/1ps
module dspl_status_pins #(
	parameter int unsigned STARTUP = dspl_pkg::STARTUP_CYCLES
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic port_select_n,
	input wire logic read_valid,
	input wire logic [19:0] pio_in,
	output logic [19:0] pio_out,
	output logic [19:0] pio_oe,
	input wire logic [31:0] header,
	input wire logic header_valid,
	input wire logic frame_bad,
	input wire logic frame_start,
	input wire logic need_data,
	input wire logic anc_read,
	input wire logic xfer_req_core,
	input wire logic xfer_end_core,
	output logic xfer_read_request,
	output logic xfer_end,
	output logic xfer_write_request,
	input wire logic wake_enable,
	input wire logic ref_clock_valid,
	input wire logic synth_locked,
	output logic clock_ready,
	output logic core_enable,
	output logic converter_enable,
	input wire logic [7:0] supply_level,
	input wire logic [7:0] supply_th_wr,
	input wire logic supply_th_we,
	output logic supply_ok,
	input wire logic out_fmt_wr,
	input wire logic out_fmt_we,
	input wire logic [15:0] left_sample,
	input wire logic [15:0] right_sample,
	output logic audio_clock_out,
	output logic out_frame_ind,
	output logic out_serial_data,
	input wire logic alt_serial_sel,
	output logic alt_serial_clock,
	output logic alt_serial_frame,
	output logic alt_serial_data,
	output logic in_sel_parallel,
	output logic layer3_en,
	output logic layer2_en,
	output logic multimedia_mode,
	output logic out_fmt_32,
	output logic audio_div_en
);
	dspl_pkg::dspl_phase_t phase_q;
	logic [$clog2(STARTUP+1)-1:0] cnt_q;
	logic oper;
	logic [4:0] strap_q;
	logic fmt_q, err_q, lock_q;
	logic [31:0] hdr_q;
	logic [7:0] th_q;
	logic [5:0] bit_q;
	logic [1:0] div_q;
	logic [15:0] sh_q;
	logic ch_q, sd_q;

	assign oper = (phase_q == dspl_pkg::DSPL_OPER);

	// Start-up phase counter, then operation
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			phase_q <= dspl_pkg::DSPL_START;
			cnt_q <= '0;
		end else begin
			case (phase_q)
			dspl_pkg::DSPL_START: begin
				cnt_q <= cnt_q + 1'b1;
				if (cnt_q == STARTUP[$bits(cnt_q)-1:0] - 1'b1)
					phase_q <= dspl_pkg::DSPL_OPER;
			end
			dspl_pkg::DSPL_OPER: phase_q <= dspl_pkg::DSPL_OPER;
			default: phase_q <= dspl_pkg::DSPL_START;
			endcase
		end
	end

	// Straps sampled once as the start-up phase ends
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			strap_q <= '0;
		end else if (!oper &&
			cnt_q == STARTUP[$bits(cnt_q)-1:0] - 1'b1) begin
			strap_q <= {pio_in[8], pio_in[4], pio_in[3],
				pio_in[2], pio_in[0]};
		end
	end
	assign audio_div_en = strap_q[4];
	assign in_sel_parallel = strap_q[3];
	assign layer3_en = strap_q[2];
	assign layer2_en = strap_q[1];
	assign multimedia_mode = strap_q[0];

	// Output format: strap first, later rewritable
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			fmt_q <= 1'b0;
		else if (!oper && cnt_q == STARTUP[$bits(cnt_q)-1:0] - 1'b1)
			fmt_q <= pio_in[1];
		else if (oper && out_fmt_we)
			fmt_q <= out_fmt_wr;
	end
	assign out_fmt_32 = fmt_q;

	// Decode error spans the frame after a failure
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			err_q <= 1'b0;
		else if (frame_start)
			err_q <= frame_bad;
	end

	// Frame lock: set wins over ancillary-read clear
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			lock_q <= 1'b0;
		else if (oper && header_valid && (layer2_en || layer3_en))
			lock_q <= 1'b1;
		else if (anc_read)
			lock_q <= 1'b0;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			hdr_q <= '0;
		else if (oper && header_valid)
			hdr_q <= header;
	end

	// Status drive: only selected, valid and in operation mode
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pio_out <= '0;
			pio_oe <= '0;
		end else begin
			pio_out <= '0;
			pio_oe <= '0;
			if (oper && !port_select_n && read_valid) begin
				pio_out[19] <= multimedia_mode & need_data;
				pio_out[18] <= hdr_q[dspl_pkg::HDR_VER_EXT];
				pio_out[17] <= hdr_q[dspl_pkg::HDR_VER];
				pio_out[13] <= hdr_q[dspl_pkg::HDR_LAYER_LO];
				pio_out[12] <= hdr_q[dspl_pkg::HDR_LAYER_HI];
				pio_out[8] <= err_q;
				pio_out[4] <= lock_q;
				pio_out[3] <= hdr_q[dspl_pkg::HDR_FS_A];
				pio_out[2] <= hdr_q[dspl_pkg::HDR_FS_B];
				pio_out[1] <= hdr_q[dspl_pkg::HDR_EMPH_LO];
				pio_out[0] <= hdr_q[dspl_pkg::HDR_EMPH_HI];
				pio_oe <= 20'he311f;
			end
		end
	end

	// Alternative serial input taken from lines 16..14
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			alt_serial_clock <= 1'b0;
			alt_serial_frame <= 1'b0;
			alt_serial_data <= 1'b0;
		end else begin
			alt_serial_clock <= alt_serial_sel & pio_in[16];
			alt_serial_frame <= alt_serial_sel & pio_in[15];
			alt_serial_data <= alt_serial_sel & pio_in[14];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			xfer_read_request <= 1'b0;
			xfer_end <= 1'b0;
		end else begin
			xfer_read_request <= oper & in_sel_parallel
				& xfer_req_core;
			xfer_end <= oper & in_sel_parallel & xfer_end_core;
		end
	end
	assign xfer_write_request = 1'b0;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			clock_ready <= 1'b0;
			core_enable <= 1'b0;
			converter_enable <= 1'b0;
		end else begin
			clock_ready <= wake_enable ? synth_locked
				: ref_clock_valid;
			core_enable <= wake_enable;
			converter_enable <= wake_enable;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			th_q <= dspl_pkg::SUPPLY_TH_RST;
			supply_ok <= 1'b0;
		end else begin
			if (supply_th_we)
				th_q <= supply_th_wr;
			supply_ok <= supply_level > th_q;
		end
	end

	// Serial output: audio clock divided from clk, data on falling phase
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_q <= '0;
			bit_q <= '0;
			ch_q <= 1'b0;
			sh_q <= '0;
			sd_q <= 1'b0;
			audio_clock_out <= 1'b0;
		end else if (audio_div_en && oper) begin
			div_q <= div_q + 1'b1;
			audio_clock_out <= div_q[1];
			if (div_q == 2'h3) begin
				sd_q <= sh_q[15];
				if (bit_q[3:0] == 4'hf) begin
					bit_q <= '0;
					ch_q <= ~ch_q;
					sh_q <= ch_q ? left_sample : right_sample;
				end else begin
					bit_q <= bit_q + 1'b1;
					sh_q <= {sh_q[14:0], 1'b0};
				end
			end
		end else begin
			audio_clock_out <= 1'b0;
		end
	end
	assign out_frame_ind = ch_q ^ fmt_q;
	assign out_serial_data = sd_q;

	// Checks on the pins that the controller and the core watch
	lock_set_a: assert property (@(posedge clk)
		disable iff (!reset_n)
		oper && header_valid && (layer2_en || layer3_en) |=> lock_q)
		else $error("lock not set");
	lock_clear_a: assert property (@(posedge clk)
		disable iff (!reset_n)
		anc_read && !header_valid |=> !lock_q)
		else $error("lock not cleared");
	lock_hold_a: assert property (@(posedge clk)
		disable iff (!reset_n)
		lock_q && !anc_read |=> lock_q)
		else $error("lock dropped");
	drive_gate_a: assert property (@(posedge clk)
		disable iff (!reset_n)
		(port_select_n || !read_valid || !oper) |=> pio_oe == 20'h0)
		else $error("pio driven");
	drive_on_a: assert property (@(posedge clk)
		disable iff (!reset_n)
		oper && !port_select_n && read_valid |=> pio_oe == 20'he311f)
		else $error("pio not driven");
	start_quiet_a: assert property (@(posedge clk)
		disable iff (!reset_n)
		!oper |=> pio_oe == 20'h0)
		else $error("start drive");
	data_req_a: assert property (@(posedge clk)
		disable iff (!reset_n)
		oper && !port_select_n && read_valid && multimedia_mode &&
		need_data |=> pio_out[19])
		else $error("no data request");
	err_frame_a: assert property (@(posedge clk)
		disable iff (!reset_n)
		frame_start && frame_bad ##1 !frame_start |-> err_q)
		else $error("error not held");
	err_clear_a: assert property (@(posedge clk)
		disable iff (!reset_n)
		frame_start && !frame_bad |=> !err_q)
		else $error("error not cleared");
	err_hold_a: assert property (@(posedge clk)
		disable iff (!reset_n)
		!frame_start |=> $stable(err_q))
		else $error("error changed mid frame");
	ready_wake_a: assert property (@(posedge clk)
		disable iff (!reset_n)
		wake_enable && !synth_locked |=> !clock_ready)
		else $error("ready early");
	ready_lock_a: assert property (@(posedge clk)
		disable iff (!reset_n)
		wake_enable && synth_locked |=> clock_ready)
		else $error("ready late");
	ready_ref_a: assert property (@(posedge clk)
		disable iff (!reset_n)
		!wake_enable |=> clock_ready == $past(ref_clock_valid))
		else $error("ready mismatch");
	core_wake_a: assert property (@(posedge clk)
		disable iff (!reset_n)
		wake_enable |=> core_enable && converter_enable)
		else $error("core not woken");
	xfer_mode_a: assert property (@(posedge clk)
		disable iff (!reset_n)
		(xfer_read_request || xfer_end) |->
		in_sel_parallel && !xfer_write_request)
		else $error("xfer misuse");
	xfer_off_a: assert property (@(posedge clk)
		disable iff (!reset_n)
		!in_sel_parallel |=> !xfer_read_request && !xfer_end)
		else $error("xfer outside parallel mode");
	alt_off_a: assert property (@(posedge clk)
		disable iff (!reset_n)
		!alt_serial_sel |=> !alt_serial_clock && !alt_serial_frame &&
		!alt_serial_data)
		else $error("alt serial leaks");
	aclk_off_a: assert property (@(posedge clk)
		disable iff (!reset_n)
		!(audio_div_en && oper) |=> !audio_clock_out)
		else $error("audio clock runs");
	strap_hold_a: assert property (@(posedge clk)
		disable iff (!reset_n)
		$past(oper) |-> $stable(strap_q))
		else $error("strap changed");
	cover property (@(posedge clk) disable iff (!reset_n)
		oper && !port_select_n && read_valid);
	cover property (@(posedge clk) disable iff (!reset_n) lock_q && anc_read);
	cover property (@(posedge clk) disable iff (!reset_n) err_q);
	cover property (@(posedge clk) disable iff (!reset_n)
		wake_enable && clock_ready);
endmodule

// ### logic/dspl_pkg.sv
// Shared constants of the decoder status pin logic.
// Assumes a single 100 MHz clock and an active-low asynchronous reset.
// How it works
// - Status outputs drive only when selected and valid.
// - Start-up reads straps from parallel data lines.
// - Handshake ignored until operation mode begins.
// - Multimedia mode raises data request when needed.
// - Decode error held for one whole frame.
// - Frame lock clear at reset, set on header with layer 2 or 3 enabled.
// - Ancillary readout clears frame lock.
// - Operation mode copies sampling and emphasis bits.
// - Sampling bits 20,21; emphasis bits 30,31.
// - Layer bits 13,14; version bits mirrored.
// - Error line strap gates audio clock divider.
// - Lock line strap selects serial or parallel input.
// - Emphasis-low strap picks output format, reconfigurable.
// - Sampling straps enable layers; emphasis-high picks mode.
// - Three data lines may form alternative serial input.
// - Transfer outputs only in parallel mode; never write.
// - Wake low: clock ready shows reference clock valid.
// - Wake high: clock ready waits for synthesizer lock.
// - Wake enables core and starts converter.
// - Low reset clears all digital state but the supply threshold, which loads SUPPLY_TH_RST.
// - Output frame line marks left or right.
// - Audio clock kept synchronous with serial output.
// - Supply ok compares against adjustable threshold.
package dspl_pkg;
	localparam int unsigned STARTUP_CYCLES = 16;
	localparam int unsigned HDR_LAYER_LO = 13;
	localparam int unsigned HDR_LAYER_HI = 14;
	localparam int unsigned HDR_FS_A = 20;
	localparam int unsigned HDR_FS_B = 21;
	localparam int unsigned HDR_EMPH_LO = 30;
	localparam int unsigned HDR_EMPH_HI = 31;
	localparam int unsigned HDR_VER = 19;
	localparam int unsigned HDR_VER_EXT = 20;
	localparam int unsigned SUPPLY_W = 8;
	localparam logic [7:0] SUPPLY_TH_RST = 8'h80;
	localparam int unsigned AUDIO_DIV = 4;
	typedef enum logic [1:0] {DSPL_START, DSPL_OPER} dspl_phase_t;
endpackage

// ### dv/dspl_ctrl_model.sv
// Controller side of the parallel lines: strap levels and pin wire.
// Assumes the device releases every line whose enable is low.
`timescale 1ns/1ps
module dspl_ctrl_model (
	input wire logic [19:0] straps,
	input wire logic [19:0] pio_out,
	input wire logic [19:0] pio_oe,
	output logic [19:0] pio_in
);
	// Released lines carry the controller's strap or serial levels
	always_comb begin
		for (int i = 0; i < 20; i++) begin
			pio_in[i] = pio_oe[i] ? pio_out[i] : straps[i];
		end
	end
endmodule

// ### dv/test_dspl_status_pins.sv
// Self-checking bench for the status pin logic and controller model.
// Assumes a short start-up count so the straps settle early.
`timescale 1ns/1ps
module test_dspl_status_pins;
	localparam int SU = 4;
	logic clk, reset_n, port_select_n, read_valid, header_valid, frame_bad;
	logic frame_start, need_data, anc_read, xfer_req_core, xfer_end_core;
	logic wake_enable, ref_clock_valid, synth_locked, supply_th_we;
	logic out_fmt_wr, out_fmt_we, alt_serial_sel, xfer_read_request;
	logic xfer_end, xfer_write_request, clock_ready, core_enable, supply_ok;
	logic converter_enable, audio_clock_out, out_frame_ind, out_serial_data;
	logic alt_serial_clock, alt_serial_frame, alt_serial_data, layer3_en;
	logic in_sel_parallel, layer2_en, multimedia_mode, out_fmt_32;
	logic audio_div_en;
	logic [19:0] pio_in, pio_out, pio_oe, straps, e;
	logic [31:0] header;
	logic [7:0] supply_level, supply_th_wr;
	logic [15:0] left_sample, right_sample;
	int err_count, tests_run;
	int n_clk, n_ind, n_sd;
	logic prev;
	typedef struct {logic [31:0] h; logic ps_n, rv, nd;} dspl_row_t;
	dspl_row_t rows[4];

	dspl_status_pins #(.STARTUP(SU)) dut (.clk, .reset_n, .port_select_n,
		.read_valid, .pio_in, .pio_out, .pio_oe, .header, .header_valid,
		.frame_bad, .frame_start, .need_data, .anc_read, .xfer_req_core,
		.xfer_end_core, .xfer_read_request, .xfer_end, .xfer_write_request,
		.wake_enable, .ref_clock_valid, .synth_locked, .clock_ready,
		.core_enable, .converter_enable, .supply_level, .supply_th_wr,
		.supply_th_we, .supply_ok, .out_fmt_wr, .out_fmt_we, .left_sample,
		.right_sample, .audio_clock_out, .out_frame_ind, .out_serial_data,
		.alt_serial_sel, .alt_serial_clock, .alt_serial_frame,
		.alt_serial_data, .in_sel_parallel, .layer3_en, .layer2_en,
		.multimedia_mode, .out_fmt_32, .audio_div_en);
	dspl_ctrl_model ctrl (.straps, .pio_out, .pio_oe, .pio_in);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic summarize;
		$display("Checks %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Status pattern the controller should see when the port is selected
	function automatic logic [19:0] exp_pio(logic [31:0] h, logic nd);
		return {nd, h[dspl_pkg::HDR_VER_EXT], h[dspl_pkg::HDR_VER], 3'h0,
			h[13], h[14], 3'h0, 1'b0, 3'h0,
			1'b1, h[20], h[21], h[30], h[31]};
	endfunction

	initial begin
		{reset_n, header_valid, frame_bad, frame_start, need_data} = '0;
		{anc_read, xfer_req_core, xfer_end_core, wake_enable} = '0;
		{ref_clock_valid, synth_locked, supply_th_we, out_fmt_wr} = '0;
		{out_fmt_we, alt_serial_sel, header, supply_th_wr} = '0;
		{left_sample, right_sample, supply_level} = '0;
		{err_count, tests_run} = '0;
		port_select_n = 1'b0;
		read_valid = 1'b1;
		straps = 20'h0011d;
		rows[0] = '{32'hc0306000, 1'b0, 1'b1, 1'b1};
		rows[1] = '{32'h40082000, 1'b0, 1'b1, 1'b0};
		rows[2] = '{32'h80104000, 1'b1, 1'b1, 1'b1};
		rows[3] = '{32'h80104000, 1'b0, 1'b0, 1'b1};
		repeat (20) @(posedge clk);
		#1 reset_n = 1'b1;
		cyc(2);
		chk(pio_oe, '0);
		cyc(SU);
		chk(20'({audio_div_en, in_sel_parallel, layer3_en, layer2_en,
			multimedia_mode, out_fmt_32}), 20'h3e);
		foreach (rows[i]) begin
			header = rows[i].h;
			port_select_n = rows[i].ps_n;
			read_valid = rows[i].rv;
			need_data = rows[i].nd;
			header_valid = 1'b1;
			cyc(1);
			header_valid = 1'b0;
			cyc(3);
			e = (!rows[i].ps_n && rows[i].rv) ? 20'he311f : '0;
			chk(pio_oe, e);
			chk(pio_out & e, exp_pio(rows[i].h, rows[i].nd) & e);
		end
		port_select_n = 1'b0;
		read_valid = 1'b1;
		anc_read = 1'b1;
		cyc(1);
		anc_read = 1'b0;
		cyc(3);
		chk(20'(pio_out[4]), '0);
		{frame_bad, frame_start} = 2'h3;
		cyc(1);
		{frame_bad, frame_start} = 2'h0;
		cyc(12);
		chk(20'(pio_out[8]), 20'h1);
		frame_start = 1'b1;
		cyc(1);
		frame_start = 1'b0;
		cyc(3);
		chk(20'(pio_out[8]), '0);
		ref_clock_valid = 1'b1;
		cyc(2);
		chk(20'(clock_ready), 20'h1);
		wake_enable = 1'b1;
		cyc(2);
		chk(20'({clock_ready, core_enable, converter_enable}),
			20'h3);
		synth_locked = 1'b1;
		cyc(2);
		chk(20'(clock_ready), 20'h1);
		{xfer_req_core, xfer_end_core} = 2'h3;
		cyc(2);
		chk(20'({xfer_read_request, xfer_end, xfer_write_request}),
			20'h6);
		supply_level = 8'h81;
		cyc(2);
		chk(20'(supply_ok), 20'h1);
		supply_level = 8'h80;
		cyc(2);
		chk(20'(supply_ok), '0);
		supply_th_wr = 8'h7f;
		supply_th_we = 1'b1;
		cyc(1);
		supply_th_we = 1'b0;
		cyc(2);
		chk(20'(supply_ok), 20'h1);
		alt_serial_sel = 1'b1;
		straps = 20'h14000;
		cyc(2);
		chk(20'({alt_serial_clock, alt_serial_frame, alt_serial_data}),
			20'h5);
		chk(20'({audio_div_en, in_sel_parallel, layer3_en, layer2_en,
			multimedia_mode, out_fmt_32}), 20'h3e);
		out_fmt_wr = 1'b1;
		out_fmt_we = 1'b1;
		cyc(1);
		out_fmt_we = 1'b0;
		cyc(2);
		chk(20'(out_fmt_32), 20'h1);
		left_sample = 16'h8000;
		right_sample = 16'h8000;
		cyc(130);
		{n_clk, n_ind, n_sd} = '0;
		prev = out_frame_ind;
		repeat (128) begin
			cyc(1);
			n_clk += audio_clock_out;
			n_ind += (out_frame_ind != prev);
			n_sd += out_serial_data;
			prev = out_frame_ind;
		end
		chk(20'(n_clk), 20'h40);
		chk(20'(n_ind), 20'h2);
		chk(20'(n_sd), 20'h8);
		reset_n = 1'b0;
		#1;
		chk(pio_oe, '0);
		chk(20'({clock_ready, supply_ok, xfer_end}), '0);
		straps = 20'h00002;
		cyc(2);
		reset_n = 1'b1;
		cyc(2);
		chk(pio_oe, '0);
		cyc(SU);
		chk(20'({audio_div_en, in_sel_parallel, layer3_en, layer2_en,
			multimedia_mode, out_fmt_32}), 20'h1);
		header = 32'hc0306000;
		header_valid = 1'b1;
		cyc(1);
		header_valid = 1'b0;
		cyc(3);
		chk(pio_oe, 20'he311f);
		chk(20'({pio_out[19], pio_out[4]}), '0);
		chk(20'({xfer_read_request, xfer_end}), '0);
		chk(20'(audio_clock_out), '0);
		summarize;
	end

	initial begin
		#20000;
		err_count++;
		summarize;
	end
endmodule
